// *** shared/i2css_pkg.sv ***
// Package of constants and types for the two-wire slave status block.
// Assumes a 10 MHz system clock and a 32-bit Avalon-MM register port.
package i2css_pkg;

  // ==========================================================
  // Register byte addresses
  // ==========================================================
  localparam logic [15:0] STATUS_ADDR = 16'hf78c;  // Sticky flags, RO
  localparam logic [15:0] CLEAR_ADDR = 16'hf790;   // Write one to clear
  localparam logic [15:0] CONTROL_ADDR = 16'hf794; // Enables and address
  localparam logic [15:0] DATA_ADDR = 16'hf798;    // Tx write, rx read

  // ==========================================================
  // Status flag positions
  // ==========================================================
  localparam int STANDBY_NACK_BIT = 13;
  localparam int MISMATCH_BIT = 12;
  localparam int START_SEEN_BIT = 11;
  localparam int STOP_SEEN_BIT = 10;
  localparam int DATA_DONE_BIT = 9;
  localparam int ADDR_RECEIVED_BIT = 8;
  localparam int DIRECTION_BIT = 4;
  localparam int ADDRESSED_BIT = 3;
  localparam int TX_ERROR_BIT = 2;
  localparam int RX_ACK_BIT = 1;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] STATUS_MASK = 16'h3f1e; // Reserved read zero

  // ==========================================================
  // Control register fields
  // ==========================================================
  localparam int UNIT_ENABLE_BIT = 0;
  localparam int MISMATCH_IE_BIT = 4;
  localparam int STOP_IE_BIT = 5;
  localparam int START_IE_BIT = 6;
  localparam int OWN_ADDR_LSB = 8;
  localparam int OWN_ADDR_WIDTH = 7;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_MASK = 32'h0000_7f71;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ==========================================================
  // Byte framing counts
  // ==========================================================
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] MUTE_BYTES = 2'h2;  // Current plus next byte

  // ==========================================================
  // Types
  // ==========================================================
  // Bus-side transfer phase
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_RX_DATA = 3'b011,
    ST_RX_ACK = 3'b100,
    ST_TX_DATA = 3'b101,
    ST_TX_ACK = 3'b110
  } i2css_state_t;

  // Synchronised line levels and the events found on them
  typedef struct packed {
    logic scl_level;
    logic sda_level;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } i2css_line_ev_t;

endpackage

// *** design/i2css_line_sync.sv ***
// Synchroniser and event finder for the serial clock and data lines.
// Assumes both pins are asynchronous and far slower than sys_clk.
`timescale 1ns/1ps

module i2css_line_sync (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Raw pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  // Synchronised events
  output i2css_pkg::i2css_line_ev_t line_ev
);
  import i2css_pkg::*;

  // ==========================================================
  // Storage
  // ==========================================================
  logic [1:0] meta;   // First stage, read only by the second
  logic [1:0] stable; // Second stage, safe to decode
  logic [1:0] last;   // Previous stable value for edges

  // ==========================================================
  // Named decodes, bit 1 is clock, bit 0 is data
  // ==========================================================
  wire scl_high = stable[1] & last[1];
  wire sda_fell = last[0] & ~stable[0];
  wire sda_rose = ~last[0] & stable[0];

  assign line_ev.scl_level = stable[1];
  assign line_ev.sda_level = stable[0];
  assign line_ev.scl_rise = stable[1] & ~last[1];
  assign line_ev.scl_fall = ~stable[1] & last[1];
  // Data moving under a steady high clock frames a transfer
  assign line_ev.start = scl_high & sda_fell;
  assign line_ev.stop = scl_high & sda_rose;

  // ==========================================================
  // Two-stage synchroniser plus history
  // ==========================================================
  // Idle lines rest high, so reset to high avoids false events
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      meta <= 2'h3;
      stable <= 2'h3;
      last <= 2'h3;
    end else if (clk_en) begin
      meta <= {scl_pin, sda_pin};
      stable <= meta;
      last <= stable;
    end
  end

endmodule

// *** design/i2css_top.sv ***
// Slave side of a two-wire serial unit with its sticky status flags.
// Assumes an Avalon-MM master on sys_clk and an open-drain data pad.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Behaviour
// - Flags zero on reset and on clear writes
// - Standby address match with nack sets bit 13
// - Enabled address mismatch after start sets bit 12
// - Start condition sets bit 11
// - Stop condition sets bit 10
// - Each addressed data byte sets bit 9
// - Standby wake transfer never sets bit 9
// - Matching address byte sets bit 8, not in standby
// - Master read sets direction bit 4
// - Stop or master write clears direction
// - Address match sets bit 3, not in standby
// - Stop clears bit 3
// - Driven bit differing from line sets bit 2
// - After error, release data line through next byte
// - Bit 1 holds each acknowledge level seen
// - Clear bits sit at flag positions
// - Control bit 6 enables start flag
// - Control bit 5 enables stop flag
module i2css_top (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Avalon-MM register slave
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Serial bus pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_out,
  output logic sda_oe_n,
  // Power manager level, same clock domain
  input wire logic deep_standby
);
  import i2css_pkg::*;

  // ==========================================================
  // Functions
  // ==========================================================
  // Replace only the byte lanes the master enabled
  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] mask;
    mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_v & ~mask) | (new_v & mask);
  endfunction

  // Direction bit of the address byte as seen after the shift
  function automatic logic rw_read(input logic [7:0] addr_byte);
    return addr_byte[0];
  endfunction

  // ==========================================================
  // Declarations
  // ==========================================================
  i2css_line_ev_t line;         // Synchronised line view
  i2css_state_t state;          // Transfer phase
  i2css_state_t next_state;
  logic [15:0] status;          // Sticky flags
  logic [15:0] next_status;
  logic [15:0] hw_set;          // Flags set by bus events
  logic [15:0] hw_clr;          // Flags cleared by bus events
  logic [31:0] control;         // Enables and own address
  logic [7:0] tx_data;          // Byte to send on master reads
  logic [7:0] rx_data;          // Last byte taken from the master
  logic [7:0] next_rx;
  logic [7:0] shift;            // Serial shifter, msb first
  logic [7:0] next_shift;
  logic [3:0] bit_cnt;          // Bits seen in this byte
  logic [3:0] next_bit_cnt;
  logic [1:0] mute_cnt;         // Byte ends left while muted
  logic [1:0] next_mute;
  logic woke;                   // Current match came in standby
  logic next_woke;
  logic got_nack;               // Master ended a read
  logic next_nack;
  logic next_oe_n;

  // ==========================================================
  // Line synchroniser
  // ==========================================================
  i2css_line_sync u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .line_ev(line)
  );

  // ==========================================================
  // Register bus decode
  // ==========================================================
  wire bus_req = avs_read | avs_write;
  wire bus_first = bus_req & avs_waitrequest;   // Request just seen
  wire wr_take = avs_write & ~avs_waitrequest;  // Write completes here
  wire hit_status = avs_address == STATUS_ADDR;
  wire hit_clear = avs_address == CLEAR_ADDR;
  wire hit_control = avs_address == CONTROL_ADDR;
  wire hit_data = avs_address == DATA_ADDR;
  wire [31:0] clear_bits = byte_merge(32'h0000_0000, avs_writedata,
                                      avs_byteenable);
  wire [31:0] next_control = byte_merge(control, avs_writedata,
                                        avs_byteenable) & CONTROL_MASK;
  wire [31:0] next_tx_word = byte_merge({24'h000000, tx_data},
                                        avs_writedata, avs_byteenable);
  // Clear bits match flag bits
  wire [15:0] sw_clear = (wr_take & hit_clear) ? clear_bits[15:0]
                                              : 16'h0000;
  // Pure selection, so a read never disturbs a flag
  wire [31:0] rd_mux = hit_status ? {16'h0000, status} :
                       hit_control ? control :
                       hit_data ? {24'h000000, rx_data} : 32'h0000_0000;

  // ==========================================================
  // Control field decode
  // ==========================================================
  wire unit_en = control[UNIT_ENABLE_BIT];
  wire mismatch_ie = control[MISMATCH_IE_BIT];
  wire stop_ie = control[STOP_IE_BIT];
  wire start_ie = control[START_IE_BIT];
  wire [6:0] own_addr = control[OWN_ADDR_LSB +: OWN_ADDR_WIDTH];
  wire addr_match = shift[7:1] == own_addr;
  wire byte_full = bit_cnt == BITS_PER_BYTE;
  wire muted = mute_cnt != 2'h0;
  wire [1:0] mute_dec = muted ? mute_cnt - 2'h1 : 2'h0;

  // ==========================================================
  // Avalon slave handshake
  // ==========================================================
  // One wait cycle per access; read data is frozen with the answer
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en) begin
      avs_waitrequest <= ~bus_first;
      if (bus_first && avs_read) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // ==========================================================
  // Software registers
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      control <= CONTROL_RESET;
      tx_data <= DATA_RESET;
    end else if (clk_en) begin
      if (wr_take & hit_control) begin
        control <= next_control;
      end
      if (wr_take & hit_data) begin
        tx_data <= next_tx_word[7:0];
      end
    end
  end

  // ==========================================================
  // Transfer engine, next values
  // ==========================================================
  // Data pad changes only after a clock fall, so the master sees
  // a stable level at its rising edge
  always_comb begin
    next_state = state;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_mute = mute_cnt;
    next_woke = woke;
    next_nack = got_nack;
    next_rx = rx_data;
    next_oe_n = sda_oe_n;
    hw_set = 16'h0000;
    hw_clr = 16'h0000;
    if (!unit_en) begin
      // Unit stopped: release the line
      next_state = ST_IDLE;
      next_oe_n = 1'b1;
      next_mute = 2'h0;
    end else if (line.stop) begin
      next_state = ST_IDLE;
      next_oe_n = 1'b1;
      next_mute = 2'h0;
      hw_clr[DIRECTION_BIT] = 1'b1;
      hw_clr[ADDRESSED_BIT] = 1'b1;
      hw_set[STOP_SEEN_BIT] = stop_ie;
    end else if (line.start) begin
      // Also covers a repeated start inside a transfer
      next_state = ST_ADDR;
      next_bit_cnt = 4'h0;
      next_oe_n = 1'b1;
      next_mute = 2'h0;
      hw_set[START_SEEN_BIT] = start_ie;
    end else if (line.scl_rise) begin
      case (state)
        ST_ADDR, ST_RX_DATA: begin
          next_shift = {shift[6:0], line.sda_level};
          next_bit_cnt = bit_cnt + 4'h1;
        end
        ST_TX_DATA: begin
          next_bit_cnt = bit_cnt + 4'h1;
          // Line differs from our bit: lost the bus
          if (!muted && (line.sda_level != shift[7])) begin
            hw_set[TX_ERROR_BIT] = 1'b1;
            next_mute = MUTE_BYTES;
          end
        end
        ST_ADDR_ACK, ST_RX_ACK, ST_TX_ACK: begin
          // Record whatever level the ninth bit carries
          hw_set[RX_ACK_BIT] = line.sda_level;
          hw_clr[RX_ACK_BIT] = ~line.sda_level;
          if (state == ST_TX_ACK) begin
            next_nack = line.sda_level;
          end
        end
        default: begin
        end
      endcase
    end else if (line.scl_fall) begin
      case (state)
        ST_ADDR: begin
          if (byte_full) begin
            next_bit_cnt = 4'h0;
            next_nack = 1'b0;
            if (addr_match && deep_standby) begin
              // Wake request: answer high and do no transfer
              hw_set[STANDBY_NACK_BIT] = 1'b1;
              next_woke = 1'b1;
              next_oe_n = 1'b1;
              next_state = ST_ADDR_ACK;
            end else if (addr_match) begin
              hw_set[ADDR_RECEIVED_BIT] = 1'b1;
              hw_set[ADDRESSED_BIT] = 1'b1;
              hw_set[DIRECTION_BIT] = shift[0];
              hw_clr[DIRECTION_BIT] = ~shift[0];
              next_woke = 1'b0;
              next_oe_n = 1'b0;
              next_state = ST_ADDR_ACK;
            end else begin
              hw_set[MISMATCH_BIT] = mismatch_ie;
              next_state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          next_bit_cnt = 4'h0;
          next_mute = mute_dec;
          if (woke) begin
            next_oe_n = 1'b1;
            next_state = ST_IDLE;
          end else if (rw_read(shift)) begin
            next_shift = tx_data;
            next_oe_n = tx_data[7] | (mute_dec != 2'h0);
            next_state = ST_TX_DATA;
          end else begin
            next_oe_n = 1'b1;
            next_state = ST_RX_DATA;
          end
        end
        ST_RX_DATA: begin
          if (byte_full) begin
            next_rx = shift;
            hw_set[DATA_DONE_BIT] = 1'b1;
            next_oe_n = muted;  // Acknowledge low unless muted
            next_state = ST_RX_ACK;
          end
        end
        ST_TX_DATA: begin
          if (byte_full) begin
            hw_set[DATA_DONE_BIT] = 1'b1;
            next_oe_n = 1'b1;  // Master owns the ninth bit
            next_state = ST_TX_ACK;
          end else begin
            next_shift = {shift[6:0], 1'b0};
            next_oe_n = shift[6] | muted;
          end
        end
        ST_RX_ACK: begin
          next_bit_cnt = 4'h0;
          next_mute = mute_dec;
          next_oe_n = 1'b1;
          next_state = ST_RX_DATA;
        end
        ST_TX_ACK: begin
          next_bit_cnt = 4'h0;
          next_mute = mute_dec;
          if (got_nack) begin
            // Master declined more data; wait for stop
            next_oe_n = 1'b1;
            next_state = ST_IDLE;
          end else begin
            next_shift = tx_data;
            next_oe_n = tx_data[7] | (mute_dec != 2'h0);
            next_state = ST_TX_DATA;
          end
        end
        default: begin
        end
      endcase
    end
    // Set after clear, so a same-cycle event survives
    next_status = ((status & ~sw_clear & ~hw_clr) | hw_set) & STATUS_MASK;
  end

  // ==========================================================
  // Transfer engine state
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      mute_cnt <= 2'h0;
      woke <= 1'b0;
      got_nack <= 1'b0;
      rx_data <= DATA_RESET;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (clk_en) begin
      state <= next_state;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      mute_cnt <= next_mute;
      woke <= next_woke;
      got_nack <= next_nack;
      rx_data <= next_rx;
      sda_out <= 1'b0;  // Open drain: only ever pulls low
      sda_oe_n <= next_oe_n;
    end
  end

  // ==========================================================
  // Status flags
  // ==========================================================
  // A stopped unit holds every flag at its reset value
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      status <= STATUS_RESET;
    end else if (clk_en) begin
      status <= unit_en ? next_status : STATUS_RESET;
    end
  end

endmodule

// *** verification/i2css_bus_master.sv ***
// Behavioural two-wire bus master that drives the slave's pins.
// Assumes an open-drain data line resolved with a pull-up by the bench.
`timescale 1ns/1ps

module i2css_bus_master (
  // Clock used for pacing
  input wire logic sys_clk,
  // Resolved data line level
  input wire logic sda_line,
  // Master-driven clock and data release
  output logic scl_pin,
  output logic sda_drv
);
  // Idle bus: both lines released high
  initial begin
    scl_pin = 1'b1;
    sda_drv = 1'b1;
  end

  // ==========================================================
  // Bit timing: 800 ns period, low 5 cycles, high 3 cycles
  // ==========================================================
  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Long low phase leaves room for the slave's resync latency
  task automatic bit_io(input logic b, output logic s);
    scl_pin <= 1'b0;
    ticks(3);
    sda_drv <= b;
    ticks(2);
    scl_pin <= 1'b1;
    ticks(2);
    s = sda_line;
    ticks(1);
  endtask

  // Start or repeated start: data falls while clock is high
  task automatic start_cond();
    scl_pin <= 1'b0;
    ticks(3);
    sda_drv <= 1'b1;
    ticks(2);
    scl_pin <= 1'b1;
    ticks(4);
    sda_drv <= 1'b0;
    ticks(4);
  endtask

  // Stop: data rises while clock is high
  task automatic stop_cond();
    scl_pin <= 1'b0;
    ticks(3);
    sda_drv <= 1'b0;
    ticks(2);
    scl_pin <= 1'b1;
    ticks(4);
    sda_drv <= 1'b1;
    ticks(4);
  endtask

  // Byte msb first, then the ninth bit
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack);
  endtask
endmodule

// *** verification/i2css_top_assertions.sv ***
// Port-level checker for the slave status block.
// Assumes it is bound to i2css_top and sees only its ports.
`timescale 1ns/1ps

module i2css_top_checker
  import i2css_pkg::*;
(
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register port
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Serial pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Power manager level
  input wire logic deep_standby
);
  // Decoded addresses
  wire logic mapped = (avs_address == STATUS_ADDR) ||
    (avs_address == CLEAR_ADDR) || (avs_address == CONTROL_ADDR) ||
    (avs_address == DATA_ADDR);
  // All on sys_clk
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // Register port
  // ==========================================================
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest && clk_en |=>
      !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer)
    else $error("late answer");
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse)
    else $error("long answer");
  property p_wait_cause;
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
  endproperty
  a_wait_cause: assert property (p_wait_cause)
    else $error("stray answer");
  property p_reserved_zero;
    !avs_waitrequest && avs_read && avs_address == STATUS_ADDR |->
      avs_readdata[31:16] == 16'h0000 &&
      (avs_readdata[15:0] & ~STATUS_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit set");
  property p_unmapped_zero;
    !avs_waitrequest && avs_read && !mapped |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read nonzero");
  property p_readdata_hold;
    $changed(avs_readdata) |-> !avs_waitrequest && avs_read;
  endproperty
  a_readdata_hold: assert property (p_readdata_hold)
    else $error("read data moved");
  // Reset state: never disabled
  property p_reset_state;
    disable iff (1'b0)
    !reset_n && clk_en |=>
      avs_waitrequest && avs_readdata == 32'h0 && sda_oe_n;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("bad reset outputs");

  // ==========================================================
  // Serial data pad
  // ==========================================================
  property p_sda_out_zero;
    sda_out == 1'b0;
  endproperty
  a_sda_out_zero: assert property (p_sda_out_zero)
    else $error("data output not zero");
  // Pulling low with clock high would fake a start condition
  property p_pull_in_low;
    $fell(sda_oe_n) |-> !scl_pin;
  endproperty
  a_pull_in_low: assert property (p_pull_in_low)
    else $error("pull with clock high");
  property p_standby_silent;
    deep_standby && $past(deep_standby) |-> !$fell(sda_oe_n);
  endproperty
  a_standby_silent: assert property (p_standby_silent)
    else $error("ack in standby");
endmodule

bind i2css_top i2css_top_checker u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
  .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .scl_pin(scl_pin),
  .sda_pin(sda_pin), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .deep_standby(deep_standby)
);

// *** verification/i2css_top_tb.sv ***
// Self-checking bench for the slave status flags.
// Assumes the master model and checker are compiled before it.
`timescale 1ns/1ps

module i2css_top_tb;
  import i2css_pkg::*;
  // Control words: enable, flag enables, own address 0x2a
  localparam logic [31:0] CTL_ALL = 32'h0000_2a71;
  localparam logic [31:0] CTL_MIS = 32'h0000_2a11;
  localparam logic [31:0] CTL_SB = 32'h0000_2a01;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic scl_pin, sda_drv, sda_out, sda_oe_n;
  logic deep_standby = 1'b0;
  // Pull-up resolves the open-drain line
  wire logic sda_line = sda_drv & (sda_oe_n | sda_out);
  int n_errors = 0;
  int compares = 0;
  logic [7:0] rx;
  logic ack;

  // Enables tied: byte lanes all on, clock always enabled
  i2css_top DUT (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_pin(scl_pin),
    .sda_pin(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .deep_standby(deep_standby));
  i2css_bus_master u_m (.sys_clk(sys_clk), .sda_line(sda_line),
    .scl_pin(scl_pin), .sda_drv(sda_drv));

  // 10 MHz system clock
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic results();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon access; request held until waitrequest samples low
  task automatic bus(input logic wr, input logic [15:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      n_errors++;
      results();
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  // Start plus address byte
  task automatic adr(input logic [7:0] b, input logic e);
    u_m.start_cond();
    u_m.xfer(b, 1'b1, rx, ack);
    chk({31'h0, ack}, {31'h0, e});
  endtask

  task automatic t_reset();
    rd_chk(STATUS_ADDR, 32'h0);
    rd_chk(CONTROL_ADDR, 32'h0);
    wr(STATUS_ADDR, 32'hffff);
    rd_chk(STATUS_ADDR, 32'h0);
    rd_chk(16'hf7a0, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_write();
    wr(CONTROL_ADDR, CTL_ALL);
    adr(8'h54, 1'b0);
    u_m.xfer(8'h3c, 1'b1, rx, ack);
    chk({31'h0, ack}, 32'h0);
    rd_chk(STATUS_ADDR, 32'h0b08);
    rd_chk(STATUS_ADDR, 32'h0b08);
    u_m.stop_cond();
    rd_chk(STATUS_ADDR, 32'h0f00);
    rd_chk(DATA_ADDR, 32'h3c);
    wr(CLEAR_ADDR, 32'h0100);
    rd_chk(STATUS_ADDR, 32'h0e00);
    wr(CLEAR_ADDR, 32'hffff);
    rd_chk(STATUS_ADDR, 32'h0);
    $display("test write done");
  endtask

  task automatic t_read();
    wr(DATA_ADDR, 32'ha5);
    adr(8'h55, 1'b0);
    u_m.xfer(8'hff, 1'b1, rx, ack);
    chk({24'h0, rx}, 32'ha5);
    rd_chk(STATUS_ADDR, 32'h0b1a);
    adr(8'h54, 1'b0);
    rd_chk(STATUS_ADDR, 32'h0b08);
    u_m.stop_cond();
    wr(CLEAR_ADDR, 32'hffff);
    $display("test read done");
  endtask

  // Master pulls the slave's first released bit low
  task automatic t_err();
    wr(DATA_ADDR, 32'h80);
    adr(8'h55, 1'b0);
    u_m.xfer(8'h7f, 1'b0, rx, ack);
    chk({24'h0, rx}, 32'h7f);
    u_m.xfer(8'hff, 1'b1, rx, ack);
    chk({24'h0, rx}, 32'hff);
    u_m.stop_cond();
    rd_chk(STATUS_ADDR, 32'h0f06);
    wr(CLEAR_ADDR, 32'hffff);
    $display("test error done");
  endtask

  // Foreign address, only mismatch flag on
  task automatic t_mis();
    wr(CONTROL_ADDR, CTL_MIS);
    adr(8'h22, 1'b1);
    u_m.stop_cond();
    rd_chk(STATUS_ADDR, 32'h1000);
    wr(CLEAR_ADDR, 32'h1000);
    $display("test mismatch done");
  endtask

  // Wake match answers high; that ninth bit is still recorded
  task automatic t_sb();
    wr(CONTROL_ADDR, CTL_SB);
    deep_standby <= 1'b1;
    adr(8'h54, 1'b1);
    u_m.stop_cond();
    deep_standby <= 1'b0;
    rd_chk(STATUS_ADDR, 32'h2002);
    $display("test standby done");
  endtask

  // Main sequence after four reset cycles
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_write();
    t_read();
    t_err();
    t_mis();
    t_sb();
    results();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    results();
  end
endmodule
